// ### rtl/intc0_map.vh
// Register offsets, field positions and codes of the interrupt control block.
`ifndef INTC0_MAP_VH
`define INTC0_MAP_VH

// Bus geometry.
`define ADDR_W 8
`define DATA_W 32
`define REG_W 8

// Byte offsets of the registers.
`define OFF_CTRL0 8'h00
`define OFF_STATUS 8'h04
`define OFF_MASK 8'h08

// Bit positions in the control register.
`define BIT_UNUSED 7
`define BIT_CMP_FLAG 6
`define BIT_EXT_FLAG 5
`define BIT_GRP0_FLAG 4
`define BIT_CMP_EN 3
`define BIT_EXT_EN 2
`define BIT_GRP0_EN 1
`define BIT_GLOBAL_EN 0

// Bit positions in the status and mask registers.
`define EV_CMP 0
`define EV_EXT 1
`define EV_GRP0 2
`define EV_W 3

// Reset values.
`define CTRL0_RST 8'h00
`define EV_RST 3'h0

// Response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### rtl/interrupt_control_reg0.v
// First interrupt control register with its AXI4-Lite slave and event interrupt.
//
// Functional notes
// - Top bit of the control register reads zero and ignores writes.
// - Comparator request flag, readable and writable, one means pending.
// - External pin request flag, readable and writable, one means pending.
// - Shared group 0 flag, writable, reads one while a sub-source is pending.
// - Comparator enable bit, zero blocks the comparator request.
// - External enable bit, zero blocks the external pin request.
// - Shared group 0 enable bit, zero blocks that group's request.
// - Global enable in bit 0, zero blocks every core request but not irq_o.

`include "intc0_map.vh"

module interrupt_control_reg0 (
   // Clock, reset and clock enable.
   input wire clk_i,
   input wire rst_n_i,
   input wire ce_i,
   // Event sources.
   input wire cmp_event_i,
   input wire ext_pin_i,
   input wire grp0_pend_i,
   // Requests to the processor core.
   output reg [2:0] core_req_o,
   // Interrupt output.
   output reg irq_o,
   // AXI4-Lite write address channel.
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [`ADDR_W-1:0] s_axi_awaddr,
   // AXI4-Lite write data channel.
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   input wire [`DATA_W-1:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   // AXI4-Lite write response channel.
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   output reg [1:0] s_axi_bresp,
   // AXI4-Lite read address channel.
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   input wire [`ADDR_W-1:0] s_axi_araddr,
   // AXI4-Lite read data channel.
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [`DATA_W-1:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp
);

   // Reset synchroniser state and the internal reset.
   reg rst_meta;
   reg rst_sync;
   wire rst_n;

   // External pin synchroniser and edge history.
   reg ext_meta;
   reg ext_sync;
   reg ext_prev;

   // Control register fields.
   reg cmp_req_flag;
   reg ext_pin_req_flag;
   reg shared_group0_req_flag;
   reg cmp_irq_enable;
   reg ext_irq_enable;
   reg shared_group0_enable;
   reg global_irq_enable;

   // Sticky event status and its mask.
   reg [`EV_W-1:0] ev_status;
   reg [`EV_W-1:0] ev_mask;

   // Captured write address and data.
   reg aw_full;
   reg w_full;
   reg [`ADDR_W-1:0] aw_addr;
   reg [`DATA_W-1:0] w_data;
   reg w_lane0;

   // Decoded write.
   wire wr_go;
   wire wr_ctrl;
   wire wr_status;
   wire wr_mask;
   wire wr_hit;

   // Hardware set terms.
   wire ext_rise;
   wire [`EV_W-1:0] ev_set;

   // Next values of the flags and status.
   reg next_cmp_flag;
   reg next_ext_flag;
   reg next_grp0_flag;
   reg [`EV_W-1:0] next_status;

   // Read side.
   reg [`REG_W-1:0] ctrl0_view;
   reg [`DATA_W-1:0] rd_word;
   reg rd_hit;

   // Reset enters asynchronously and is released through two flip-flops.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   assign rst_n = rst_sync;

   // The pin is asynchronous, so only the second flop feeds the edge detector.
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_prev <= 1'b0;
      end else if (ce_i) begin
         ext_meta <= ext_pin_i;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
      end
   end

   // A rising edge on the pin is one external request.
   assign ext_rise = ext_sync & ~ext_prev;

   // Events that set the sticky status bits.
   assign ev_set[`EV_CMP] = cmp_event_i;
   assign ev_set[`EV_EXT] = ext_rise;
   assign ev_set[`EV_GRP0] = grp0_pend_i & ~shared_group0_req_flag;

   // A write is performed once both address and data are held and no answer waits.
   assign wr_go = aw_full & w_full & ~s_axi_bvalid;
   assign wr_ctrl = wr_go & w_lane0 & ({aw_addr[`ADDR_W-1:2], 2'b00} == `OFF_CTRL0);
   assign wr_status = wr_go & w_lane0 & ({aw_addr[`ADDR_W-1:2], 2'b00} == `OFF_STATUS);
   assign wr_mask = wr_go & w_lane0 & ({aw_addr[`ADDR_W-1:2], 2'b00} == `OFF_MASK);
   assign wr_hit = ({aw_addr[`ADDR_W-1:2], 2'b00} == `OFF_CTRL0) |
                   ({aw_addr[`ADDR_W-1:2], 2'b00} == `OFF_STATUS) |
                   ({aw_addr[`ADDR_W-1:2], 2'b00} == `OFF_MASK);

   // Software may write the flags, but a hardware set in the same cycle wins.
   always @* begin
      next_cmp_flag = cmp_req_flag;
      next_ext_flag = ext_pin_req_flag;
      next_grp0_flag = shared_group0_req_flag;
      if (wr_ctrl) begin
         next_cmp_flag = w_data[`BIT_CMP_FLAG];
         next_ext_flag = w_data[`BIT_EXT_FLAG];
         next_grp0_flag = w_data[`BIT_GRP0_FLAG];
      end
      next_cmp_flag = next_cmp_flag | cmp_event_i;
      next_ext_flag = next_ext_flag | ext_rise;
      // A pending sub-source keeps the group flag up even against a clear.
      next_grp0_flag = next_grp0_flag | grp0_pend_i;
   end

   // Write one clears a status bit; a new event in that cycle keeps it set.
   always @* begin
      next_status = ev_status;
      if (wr_status) begin
         next_status = ev_status & ~w_data[`EV_W-1:0];
      end
      next_status = next_status | ev_set;
   end

   // Control register fields; bit 7 has no storage at all.
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cmp_req_flag <= 1'b0;
         ext_pin_req_flag <= 1'b0;
         shared_group0_req_flag <= 1'b0;
         cmp_irq_enable <= 1'b0;
         ext_irq_enable <= 1'b0;
         shared_group0_enable <= 1'b0;
         global_irq_enable <= 1'b0;
      end else if (ce_i) begin
         cmp_req_flag <= next_cmp_flag;
         ext_pin_req_flag <= next_ext_flag;
         shared_group0_req_flag <= next_grp0_flag;
         if (wr_ctrl) begin
            cmp_irq_enable <= w_data[`BIT_CMP_EN];
            ext_irq_enable <= w_data[`BIT_EXT_EN];
            shared_group0_enable <= w_data[`BIT_GRP0_EN];
            global_irq_enable <= w_data[`BIT_GLOBAL_EN];
         end
      end
   end

   // Status, mask and the interrupt line.
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ev_status <= `EV_RST;
         ev_mask <= `EV_RST;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         ev_status <= next_status;
         if (wr_mask) begin
            ev_mask <= w_data[`EV_W-1:0];
         end
         // Registered from next values, so the line tracks status without extra lag.
         irq_o <= |(next_status & (wr_mask ? w_data[`EV_W-1:0] : ev_mask));
      end
   end

   // Requests to the core need flag, own enable and the global enable.
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         core_req_o <= `EV_RST;
      end else if (ce_i) begin
         core_req_o[`EV_CMP] <= cmp_req_flag & cmp_irq_enable & global_irq_enable;
         core_req_o[`EV_EXT] <= ext_pin_req_flag & ext_irq_enable & global_irq_enable;
         core_req_o[`EV_GRP0] <= shared_group0_req_flag & shared_group0_enable &
                                 global_irq_enable;
      end
   end

   // Write channels are taken independently and held until the answer is taken.
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= {`ADDR_W{1'b0}};
         w_data <= {`DATA_W{1'b0}};
         w_lane0 <= 1'b0;
      end else if (ce_i) begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_full <= 1'b1;
            s_axi_awready <= 1'b0;
         end else if (~aw_full & ~s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
            w_full <= 1'b1;
            s_axi_wready <= 1'b0;
         end else if (~w_full & ~s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_go) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control register view; the unused top bit always reads zero.
   always @* begin
      ctrl0_view = `CTRL0_RST;
      ctrl0_view[`BIT_UNUSED] = 1'b0;
      ctrl0_view[`BIT_CMP_FLAG] = cmp_req_flag;
      ctrl0_view[`BIT_EXT_FLAG] = ext_pin_req_flag;
      ctrl0_view[`BIT_GRP0_FLAG] = shared_group0_req_flag;
      ctrl0_view[`BIT_CMP_EN] = cmp_irq_enable;
      ctrl0_view[`BIT_EXT_EN] = ext_irq_enable;
      ctrl0_view[`BIT_GRP0_EN] = shared_group0_enable;
      ctrl0_view[`BIT_GLOBAL_EN] = global_irq_enable;
   end

   // Read decode; narrow registers sit in the low bits, the rest reads zero.
   always @* begin
      rd_word = {`DATA_W{1'b0}};
      rd_hit = 1'b1;
      case ({s_axi_araddr[`ADDR_W-1:2], 2'b00})
         `OFF_CTRL0: begin
            rd_word[`REG_W-1:0] = ctrl0_view;
         end
         `OFF_STATUS: begin
            rd_word[`EV_W-1:0] = ev_status;
         end
         `OFF_MASK: begin
            rd_word[`EV_W-1:0] = ev_mask;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // One read at a time: the data is latched on the address handshake.
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= {`DATA_W{1'b0}};
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (~s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // interrupt_control_reg0

// ### test/event_source_model.sv
// Behavioural model of the peripheral event sources.
module event_source_model (
   // Clock.
   input wire logic clk_i,
   // Event lines.
   output logic cmp_event_o,
   output logic ext_pin_o,
   output logic grp0_pend_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // All sources idle low until the bench asks for an event.
   initial begin
      cmp_event_o = 1'b0;
      ext_pin_o = 1'b0;
      grp0_pend_o = 1'b0;
   end
   // A single-cycle comparator pulse.
   task automatic cmp_pulse();
      cmp_event_o <= 1'b1;
      @(posedge clk_i);
      cmp_event_o <= 1'b0;
   endtask
   // The pin is held several cycles so that the input synchroniser cannot miss it.
   task automatic ext_pulse();
      ext_pin_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_pin_o <= 1'b0;
   endtask
   // Group 0 pending is a level.
   task automatic grp0_set(input logic v);
      grp0_pend_o <= v;
      @(posedge clk_i);
   endtask
endmodule // event_source_model

// ### test/intc0_props.sv
// Port-level assertions for the interrupt control block.
module intc0_props (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Events and requests.
   input wire logic cmp_event_i,
   input wire logic grp0_pend_i,
   input wire logic [2:0] core_req_o,
   input wire logic irq_o,
   // Register bus.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Bus handshakes that start and end each access.
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence rd_done;
      s_axi_rvalid && s_axi_rready;
   endsequence
   AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read answer late");
   AST_RD_REOPEN: assert property (rd_done |=> !s_axi_arready ##1 s_axi_arready)
      else $error("read channel did not reopen");
   AST_WR_ANSWER: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer late");
   AST_TOP_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
      else $error("unused bits read nonzero");
   // Reset must clear requests even while the disable is active elsewhere.
   AST_RST_CLEAR: assert property (disable iff (1'b0) !rst_n_i |->
      core_req_o == 3'h0 && !irq_o && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not cleared in reset");
   AST_CMP_REQ: assert property ($rose(core_req_o[0]) |->
      $past(cmp_event_i, 2) || $past(s_axi_bvalid)) else $error("comparator request uncaused");
   AST_GRP_REQ: assert property ($rose(core_req_o[2]) |->
      $past(grp0_pend_i, 2) || $past(s_axi_bvalid)) else $error("group request uncaused");
   // Only software clears flags, status or enables, so drops follow a write.
   AST_IRQ_DROP: assert property ($fell(irq_o) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("interrupt dropped without a write");
   AST_REQ_DROP: assert property (|($past(core_req_o) & ~core_req_o) |->
      $past(s_axi_bvalid)) else $error("request dropped without a write");
endmodule // intc0_props

// ### test/interrupt_control_reg0_tb.sv
// Self-checking bench for the first interrupt control register block.
`include "intc0_map.vh"
module interrupt_control_reg0_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b1;
   logic ce = 1'b1, brdy = 1'b0, rrdy = 1'b0;
   logic [2:0] core_req_o;
   logic irq_o, cmp_w, ext_w, grp_w, awr, wr_rdy, bv, arr, rv;
   logic awv = 1'b0, wv = 1'b0, arv = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd;
   logic [1:0] br, rr;
   logic [10:0] pat [6] = '{{8'hff, 3'h7}, {8'hfe, 3'h0}, {8'hf7, 3'h6}, {8'hfb, 3'h5},
      {8'hfd, 3'h3}, {8'h8f, 3'h0}};
   int fail_count = 0;
   int total_checks = 0;
   int n;
   // Free-running 20 MHz clock.
   always #25 clk_i = ~clk_i;
   event_source_model src_u (.clk_i(clk_i), .cmp_event_o(cmp_w), .ext_pin_o(ext_w),
      .grp0_pend_o(grp_w));
   interrupt_control_reg0 dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
      .cmp_event_i(cmp_w), .ext_pin_i(ext_w), .grp0_pend_i(grp_w), .core_req_o(core_req_o),
      .irq_o(irq_o), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_bresp(br), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
      .s_axi_rdata(rd), .s_axi_rresp(rr));
   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One bounded wait cycle; a stuck slave ends the run rather than hanging it.
   task automatic tick();
      @(posedge clk_i);
      n++;
      if (n > 40) begin
         fail_count++;
         $display("mismatch at %0t: bus timeout", $time);
         tally_and_finish();
      end
   endtask
   // Write with address and data offered together, each released once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      n = 0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      do begin
         tick();
         if (awr) awv <= 1'b0;
         if (wr_rdy) wv <= 1'b0;
      end while ((awv && !awr) || (wv && !wr_rdy));
      do tick(); while (!bv);
      chk(32'(br), 32'(er));
      // Drop the response ready and let one edge pass before the next access.
      brdy <= 1'b0;
      @(posedge clk_i);
   endtask
   // Read one register and compare data and response.
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      n = 0;
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do tick(); while (!arr);
      arv <= 1'b0;
      do tick(); while (!rv);
      chk(rd, exp);
      chk(32'(rr), 32'(er));
      rrdy <= 1'b0;
      @(posedge clk_i);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence; reset is applied before the first edge so no output starts unknown.
   initial begin
      rst_n_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd_chk(`OFF_CTRL0, 32'h0, `RESP_OKAY);
      rd_chk(`OFF_STATUS, 32'h0, `RESP_OKAY);
      rd_chk(`OFF_MASK, 32'h0, `RESP_OKAY);
      $display("test reset values done");
      foreach (pat[i]) begin
         wr(`OFF_CTRL0, {24'h0, pat[i][10:3]}, `RESP_OKAY);
         rd_chk(`OFF_CTRL0, {24'h0, pat[i][10:3] & 8'h7f}, `RESP_OKAY);
         chk(32'(core_req_o), 32'(pat[i][2:0]));
      end
      $display("test enable gating done");
      src_u.cmp_pulse();
      src_u.ext_pulse();
      src_u.grp0_set(1'b1);
      repeat (4) @(posedge clk_i);
      rd_chk(`OFF_CTRL0, 32'h7f, `RESP_OKAY);
      chk(32'(core_req_o), 32'h7);
      rd_chk(`OFF_STATUS, 32'h7, `RESP_OKAY);
      chk(32'(irq_o), 32'h0);
      wr(`OFF_MASK, 32'h7, `RESP_OKAY);
      chk(32'(irq_o), 32'h1);
      wr(`OFF_CTRL0, 32'h0f, `RESP_OKAY);
      rd_chk(`OFF_CTRL0, 32'h1f, `RESP_OKAY);
      src_u.grp0_set(1'b0);
      wr(`OFF_CTRL0, 32'h0f, `RESP_OKAY);
      rd_chk(`OFF_CTRL0, 32'h0f, `RESP_OKAY);
      wr(`OFF_STATUS, 32'h7, `RESP_OKAY);
      rd_chk(`OFF_STATUS, 32'h0, `RESP_OKAY);
      chk(32'(irq_o), 32'h0);
      wr(8'h0c, 32'hff, `RESP_SLVERR);
      rd_chk(8'h0c, 32'h0, `RESP_SLVERR);
      // With the clock enable low a comparator pulse must leave no trace.
      ce <= 1'b0;
      src_u.cmp_pulse();
      ce <= 1'b1;
      rd_chk(`OFF_CTRL0, 32'h0f, `RESP_OKAY);
      rd_chk(`OFF_STATUS, 32'h0, `RESP_OKAY);
      $display("test events done");
      rst_n_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd_chk(`OFF_MASK, 32'h0, `RESP_OKAY);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule // interrupt_control_reg0_tb
bind interrupt_control_reg0 intc0_props props_u (.clk_i, .rst_n_i, .cmp_event_i, .grp0_pend_i,
   .core_req_o, .irq_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
